// file: core/quasi_bidir_port_altfunc.sv
// two quasi-bidirectional ports with alternate functions and access pin
`timescale 1ns/10ps
module quasi_bidir_port_altfunc
  import quasi_port_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              upper_write,
  input  wire logic [7:0]        upper_write_data,
  input  wire logic              lower_write,
  input  wire logic [7:0]        lower_write_data,
  input  wire logic              upper_addr_en,
  input  wire logic [7:0]        address_high,
  input  wire lower_alt_out_type lower_alt,
  input  wire logic [7:0]        upper_io_port_in,
  input  wire logic [7:0]        lower_multi_function_port_in,
  input  wire logic              external_code_select_n,
  output pin_drive_type          upper_io_port,
  output pin_drive_type          lower_multi_function_port,
  output logic [7:0]             upper_latch,
  output logic [7:0]             lower_latch,
  output logic [7:0]             upper_pin_level,
  output logic [7:0]             lower_pin_level,
  output alt_input_type          alt_inputs,
  output logic                   code_fetch_external
);

  localparam int TC_AST = TRANSITION_CYCLES;

  initial begin
    if (TRANSITION_CYCLES < 1 || TRANSITION_CYCLES >= (1 << HOLD_WIDTH)) begin
      $error("transition hold count does not fit its counter");
    end
  end

  logic [PORT_COUNT-1:0][7:0]                 latch;
  logic [PORT_COUNT-1:0][7:0]                 alt_value;
  logic [PORT_COUNT-1:0][7:0]                 full_drive;
  logic [PORT_COUNT-1:0][7:0]                 eff;
  logic [PORT_COUNT-1:0][7:0]                 prev_eff;
  logic [PORT_COUNT-1:0][7:0]                 out_level;
  logic [PORT_COUNT-1:0][7:0]                 out_en;
  logic [PORT_COUNT-1:0][7:0][HOLD_WIDTH-1:0] hold_cnt;
  logic [PORT_COUNT-1:0][7:0]                 sync_meta;
  logic [PORT_COUNT-1:0][7:0]                 sync_pin;
  logic [PORT_COUNT-1:0]                      wr_strobe;
  logic [PORT_COUNT-1:0][7:0]                 wr_data;
  logic                                       ea_meta;
  logic                                       ea_sync;

  assign wr_strobe[UPPER] = upper_write;
  assign wr_strobe[LOWER] = lower_write;
  assign wr_data[UPPER]   = upper_write_data;
  assign wr_data[LOWER]   = lower_write_data;

  // port latches written by the core
  always_ff @(posedge clk) begin
    if (rst) begin
      latch <= {PORT_COUNT{LATCH_RESET}};
    end else begin
      for (int p = 0; p < PORT_COUNT; p++) begin
        if (wr_strobe[p]) begin
          latch[p] <= wr_data[p];
        end
      end
    end
  end

  // alternate output selection; a bit without alternate use stays at 1
  always_comb begin
    alt_value  = '1;
    full_drive = '0;
    if (upper_addr_en) begin
      alt_value[UPPER]  = address_high;
      full_drive[UPPER] = '1;
    end
    if (lower_alt.tx_en) begin
      alt_value[LOWER][TX_BIT] = lower_alt.serial0_transmit_out;
    end
    if (lower_alt.strobe_en) begin
      alt_value[LOWER][WR_BIT] = lower_alt.write_n;
      alt_value[LOWER][RD_BIT] = lower_alt.read_n;
    end
  end

  // a low latch always wins over an alternate output
  assign eff = latch & alt_value;

  // pin drivers; address bus bits get active drivers both ways
  always_ff @(posedge clk) begin
    if (rst) begin
      out_level <= '1;
      out_en    <= '0;
      prev_eff  <= '1;
      hold_cnt  <= '0;
    end else begin
      prev_eff <= eff;
      for (int p = 0; p < PORT_COUNT; p++) begin
        for (int b = 0; b < PORT_WIDTH; b++) begin
          if (full_drive[p][b]) begin
            out_en[p][b]    <= 1'b1;
            out_level[p][b] <= eff[p][b];
            hold_cnt[p][b]  <= '0;
          end else if (!eff[p][b]) begin
            out_en[p][b]    <= 1'b1;
            out_level[p][b] <= 1'b0;
            hold_cnt[p][b]  <= '0;
          end else if (!prev_eff[p][b]) begin
            out_en[p][b]    <= 1'b1;
            out_level[p][b] <= 1'b1;
            hold_cnt[p][b]  <= HOLD_WIDTH'(TRANSITION_CYCLES - 1);
          end else if (hold_cnt[p][b] != '0) begin
            hold_cnt[p][b]  <= hold_cnt[p][b] - 1'b1;
          end else begin
            out_en[p][b]    <= 1'b0;
            out_level[p][b] <= 1'b1;
          end
        end
      end
    end
  end

  assign upper_io_port.level                   = out_level[UPPER];
  assign upper_io_port.drive_en                = out_en[UPPER];
  assign upper_io_port.weak_pullup             = ~out_en[UPPER];
  assign lower_multi_function_port.level       = out_level[LOWER];
  assign lower_multi_function_port.drive_en    = out_en[LOWER];
  assign lower_multi_function_port.weak_pullup = ~out_en[LOWER];
  assign upper_latch = latch[UPPER];
  assign lower_latch = latch[LOWER];

  // pins are asynchronous to clk: two flops before any use
  always_ff @(posedge clk) begin
    sync_meta[UPPER] <= upper_io_port_in;
    sync_meta[LOWER] <= lower_multi_function_port_in;
    sync_pin         <= sync_meta;
  end

  always_ff @(posedge clk) begin
    ea_meta <= external_code_select_n;
    ea_sync <= ea_meta;
  end

  // reads see the pin, not the latch, so an outside driver is visible
  assign upper_pin_level = sync_pin[UPPER];
  assign lower_pin_level = sync_pin[LOWER];

  assign alt_inputs.serial0_receive_in = sync_pin[LOWER][RX_BIT];
  assign alt_inputs.ext_irq_in_0       = sync_pin[LOWER][IRQ0_BIT];
  assign alt_inputs.ext_irq_in_1       = sync_pin[LOWER][IRQ1_BIT];
  assign alt_inputs.timer0_count_in    = sync_pin[LOWER][T0_BIT];
  assign alt_inputs.timer1_count_in    = sync_pin[LOWER][T1_BIT];

  // strap-like level; the core decides when to act on it
  assign code_fetch_external = ~ea_sync;

  default clocking ast_clk @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence seq_upper_rise;
    $rose(eff[UPPER][0]) && !full_drive[UPPER][0];
  endsequence

  sequence seq_upper_settled_high;
    eff[UPPER][0] && prev_eff[UPPER][0] && !full_drive[UPPER][0]
      && hold_cnt[UPPER][0] == '0;
  endsequence

  property prop_reset_idle;
    @(posedge clk) disable iff (1'b0)
      rst |=> (latch == {PORT_COUNT{LATCH_RESET}}) && (out_en == '0)
              && (out_level == '1);
  endproperty

  sequence seq_tx_rise;
    $rose(eff[LOWER][TX_BIT]);
  endsequence

  AST_RESET_IDLE: assert property (prop_reset_idle)
    else $error("ports not released to weak pullup after reset");

  AST_PIN_READ: assert property (
    lower_pin_level == $past(lower_multi_function_port_in, 2))
    else $error("pin level read does not follow the pin");

  AST_UPPER_PIN_READ: assert property (
    upper_pin_level == $past(upper_io_port_in, 2))
    else $error("upper pin level read does not follow the pin");

  AST_PULLDOWN: assert property (
    (!latch[UPPER][0] && !upper_addr_en)
      |=> upper_io_port.drive_en[0] && !upper_io_port.level[0])
    else $error("low latch did not give strong pulldown");

  AST_UPPER_PULLDOWN_ALL: assert property (
    !upper_addr_en
      |=> (upper_io_port.drive_en & ~upper_io_port.level)
          == ~$past(latch[UPPER]))
    else $error("upper pulldowns do not match the latch");

  AST_LOWER_PULLDOWN_ALL: assert property (
    (!lower_alt.tx_en && !lower_alt.strobe_en)
      |=> (lower_multi_function_port.drive_en
           & ~lower_multi_function_port.level) == ~$past(latch[LOWER]))
    else $error("lower pulldowns do not match the latch");

  AST_UPPER_LATCH_WR: assert property (
    upper_write |=> upper_latch == $past(upper_write_data))
    else $error("upper latch write lost");

  AST_LOWER_LATCH_WR: assert property (
    lower_write |=> lower_latch == $past(lower_write_data))
    else $error("lower latch write lost");

  AST_LATCH_KEEP: assert property (
    (!upper_write && !lower_write) |=> $stable(latch))
    else $error("latch changed without a write");

  AST_RISE_DRIVE: assert property (
    seq_upper_rise |=> upper_io_port.drive_en[0] && upper_io_port.level[0]
                       && hold_cnt[UPPER][0] == HOLD_WIDTH'(TC_AST - 1))
    else $error("no strong pull-high after rising latch");

  AST_TX_RISE: assert property (
    seq_tx_rise |=> lower_multi_function_port.drive_en[TX_BIT]
                    && lower_multi_function_port.level[TX_BIT])
    else $error("no strong pull-high after rising transmit pin");

  // counts strong-high cycles outside address mode; saturates, never wraps
  logic                addr_mode_seen;
  logic [HOLD_WIDTH:0] strong_high_run;

  always_ff @(posedge clk) begin
    addr_mode_seen <= upper_addr_en;
  end

  always_ff @(posedge clk) begin
    if (rst || addr_mode_seen
        || !(out_en[UPPER][0] && out_level[UPPER][0])) begin
      strong_high_run <= '0;
    end else if (strong_high_run != '1) begin
      strong_high_run <= strong_high_run + 1'b1;
    end
  end

  AST_STRONG_HIGH_BOUND: assert property (
    strong_high_run <= TC_AST)
    else $error("strong pull-high outlasted the transition time");

  AST_WEAK_HOLD: assert property (
    seq_upper_settled_high
      |=> !upper_io_port.drive_en[0] && upper_io_port.weak_pullup[0])
    else $error("strong driver left on after transition time");

  AST_ADDR_BUS: assert property (
    (upper_addr_en && latch[UPPER] == 8'hFF)
      |=> upper_io_port.drive_en == 8'hFF
          && upper_io_port.level == $past(address_high))
    else $error("upper port does not carry address high byte");

  AST_RX_TX: assert property (
    (alt_inputs.serial0_receive_in
       == $past(lower_multi_function_port_in[RX_BIT], 2))
    and ((lower_alt.tx_en && latch[LOWER][TX_BIT])
      |=> lower_multi_function_port.level[TX_BIT]
          == $past(lower_alt.serial0_transmit_out)))
    else $error("serial 0 pin path broken");

  AST_IRQ_IN: assert property (
    alt_inputs.ext_irq_in_0 == $past(lower_multi_function_port_in[IRQ0_BIT], 2)
    && alt_inputs.ext_irq_in_1
       == $past(lower_multi_function_port_in[IRQ1_BIT], 2))
    else $error("interrupt inputs do not follow pins");

  AST_TIMER_IN: assert property (
    alt_inputs.timer0_count_in == $past(lower_multi_function_port_in[T0_BIT], 2)
    && alt_inputs.timer1_count_in
       == $past(lower_multi_function_port_in[T1_BIT], 2))
    else $error("timer count inputs do not follow pins");

  AST_STROBES: assert property (
    (lower_alt.strobe_en && latch[LOWER][WR_BIT] && latch[LOWER][RD_BIT])
      |=> lower_multi_function_port.level[WR_BIT] == $past(lower_alt.write_n)
          && lower_multi_function_port.level[RD_BIT]
             == $past(lower_alt.read_n))
    else $error("data memory strobes not on their pins");

  AST_CODE_SELECT: assert property (
    code_fetch_external == !$past(external_code_select_n, 2))
    else $error("code select does not follow access pin");

  AST_LATCH_GATES_ALT: assert property (
    (lower_alt.tx_en && !latch[LOWER][TX_BIT])
      |=> lower_multi_function_port.drive_en[TX_BIT]
          && !lower_multi_function_port.level[TX_BIT])
    else $error("low latch did not force alternate pin low");

  AST_STROBE_GATED: assert property (
    (lower_alt.strobe_en && !latch[LOWER][RD_BIT])
      |=> lower_multi_function_port.drive_en[RD_BIT]
          && !lower_multi_function_port.level[RD_BIT])
    else $error("low latch did not force read strobe pin low");

  AST_ADDR_GATED: assert property (
    upper_addr_en
      |=> upper_io_port.level == $past(address_high & latch[UPPER]))
    else $error("address byte not gated by the upper latch");

endmodule : quasi_bidir_port_altfunc

// file: core/quasi_port_pkg.sv
// constants and carrier types for the quasi-bidirectional port block
package quasi_port_pkg;

  localparam int PORT_WIDTH = 8;
  localparam int PORT_COUNT = 2;
  localparam int UPPER      = 0;
  localparam int LOWER      = 1;

  localparam logic [7:0] LATCH_RESET = 8'hFF;

  // lower port alternate function bit positions
  localparam int RX_BIT   = 0;
  localparam int TX_BIT   = 1;
  localparam int IRQ0_BIT = 2;
  localparam int IRQ1_BIT = 3;
  localparam int T0_BIT   = 4;
  localparam int T1_BIT   = 5;
  localparam int WR_BIT   = 6;
  localparam int RD_BIT   = 7;

  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int TRANSITION_NS = 100;
  localparam int TRANSITION_RAW =
    (TRANSITION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRANSITION_CYCLES =
    (TRANSITION_RAW < 1) ? 1 : TRANSITION_RAW;
  localparam int HOLD_WIDTH = $clog2(TRANSITION_CYCLES + 1);

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] drive_en;
    logic [7:0] weak_pullup;
  } pin_drive_type;

  typedef struct packed {
    logic tx_en;
    logic serial0_transmit_out;
    logic strobe_en;
    logic write_n;
    logic read_n;
  } lower_alt_out_type;

  typedef struct packed {
    logic serial0_receive_in;
    logic ext_irq_in_0;
    logic ext_irq_in_1;
    logic timer0_count_in;
    logic timer1_count_in;
  } alt_input_type;

endpackage : quasi_port_pkg

// file: verification/pin_world.sv
// board side of the ports: outside drivers, pullups and access pin tie
`timescale 1ns/10ps
module pin_world
  import quasi_port_pkg::*;
(
  input  wire pin_drive_type upper_drive,
  input  wire pin_drive_type lower_drive,
  input  wire logic [7:0]    upper_ext_en,
  input  wire logic [7:0]    upper_ext_val,
  input  wire logic [7:0]    lower_ext_en,
  input  wire logic [7:0]    lower_ext_val,
  input  wire logic          board_external_code,
  output logic [7:0]         upper_pins,
  output logic [7:0]         lower_pins,
  output logic               external_code_select_n
);
  // a strong device drive wins; an idle pin floats up on the pullup
  function automatic logic [7:0] resolve(pin_drive_type d,
                                         logic [7:0] en, logic [7:0] val);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = d.drive_en[i] ? d.level[i] : en[i] ? val[i] : d.weak_pullup[i];
    end
    return r;
  endfunction : resolve

  assign upper_pins = resolve(upper_drive, upper_ext_en, upper_ext_val);
  assign lower_pins = resolve(lower_drive, lower_ext_en, lower_ext_val);
  assign external_code_select_n = ~board_external_code;
endmodule : pin_world

// file: verification/quasi_bidir_port_altfunc_tb.sv
// self-checking bench for the quasi-bidirectional port block
`timescale 1ns/10ps
module quasi_bidir_port_altfunc_tb
  import quasi_port_pkg::*;
;
  logic clk, rst, upper_write, lower_write, upper_addr_en, board_ext;
  logic [7:0] upper_write_data, lower_write_data, address_high;
  logic [7:0] up_en, up_val, lo_en, lo_val, upper_pins, lower_pins;
  logic [7:0] upper_latch, lower_latch, upper_pin_level, lower_pin_level;
  logic external_code_select_n, code_fetch_external;
  lower_alt_out_type lower_alt;
  pin_drive_type up_drv, lo_drv;
  alt_input_type alt_inputs;
  int failures, total_checks, cycles;

  quasi_bidir_port_altfunc i_dut (.clk(clk), .rst(rst),
    .upper_write(upper_write), .upper_write_data(upper_write_data),
    .lower_write(lower_write), .lower_write_data(lower_write_data),
    .upper_addr_en(upper_addr_en), .address_high(address_high),
    .lower_alt(lower_alt), .upper_io_port_in(upper_pins),
    .lower_multi_function_port_in(lower_pins),
    .external_code_select_n(external_code_select_n),
    .upper_io_port(up_drv), .lower_multi_function_port(lo_drv),
    .upper_latch(upper_latch), .lower_latch(lower_latch),
    .upper_pin_level(upper_pin_level), .lower_pin_level(lower_pin_level),
    .alt_inputs(alt_inputs), .code_fetch_external(code_fetch_external));

  pin_world i_world (.upper_drive(up_drv), .lower_drive(lo_drv),
    .upper_ext_en(up_en), .upper_ext_val(up_val), .lower_ext_en(lo_en),
    .lower_ext_val(lo_val), .board_external_code(board_ext),
    .upper_pins(upper_pins), .lower_pins(lower_pins),
    .external_code_select_n(external_code_select_n));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic wrap_up();
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // far above the roughly 70 cycles the scenarios need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic do_reset();
    rst = 1'h1;
    upper_addr_en = 1'h0;
    lower_alt = '0;
    up_en = 8'h00;
    lo_en = 8'h00;
    tick(8);
    rst = 1'h0;
  endtask : do_reset

  task automatic wr(input logic upper, input logic [7:0] d);
    upper_write = upper;
    lower_write = ~upper;
    upper_write_data = d;
    lower_write_data = d;
    tick(1);
    upper_write = 1'h0;
    lower_write = 1'h0;
  endtask : wr

  task automatic t_reset();
    chk(up_drv, 24'hFF_00FF);
    chk(lo_drv, 24'hFF_00FF);
    chk({upper_latch, lower_latch}, 16'hFFFF);
  endtask : t_reset

  task automatic t_input();
    up_en = 8'hFF;
    up_val = 8'h5A;
    tick(2);
    chk(upper_pin_level, 8'h5A);
    chk(up_drv.drive_en, 8'h00);
    up_en = 8'h00;
    tick(2);
    chk(upper_pin_level, 8'hFF);
  endtask : t_input

  task automatic t_pull();
    wr(1'h1, 8'hF0);
    chk(upper_latch, 8'hF0);
    tick(6);
    chk(up_drv, 24'hF0_0FF0);
    chk(upper_pin_level, 8'hF0);
    wr(1'h1, 8'hFF);
    tick(1);
    chk(up_drv, 24'hFF_0FF0);
    tick(1);
    chk(up_drv, 24'hFF_0FF0);
    tick(1);
    chk(up_drv, 24'hFF_00FF);
    wr(1'h0, 8'h00);
    tick(1);
    chk(lo_drv, 24'h00_FF00);
  endtask : t_pull

  task automatic t_addr();
    do_reset();
    upper_addr_en = 1'h1;
    address_high = 8'hA5;
    tick(1);
    chk(up_drv.level, 8'hA5);
    chk(up_drv.drive_en, 8'hFF);
    wr(1'h1, 8'h0F);
    tick(3);
    chk(up_drv.level, 8'h05);
    chk(upper_pin_level, 8'h05);
  endtask : t_addr

  task automatic t_lower_alt();
    do_reset();
    lower_alt = '{tx_en: 1'h1, serial0_transmit_out: 1'h0,
                  strobe_en: 1'h1, write_n: 1'h0, read_n: 1'h1};
    tick(1);
    chk(lo_drv.level, 8'hBD);
    chk({lo_drv.drive_en[6], lo_drv.drive_en[1]}, 2'h3);
    tick(2);
    chk(lower_pin_level, 8'hBD);
    wr(1'h0, 8'h7F);
    tick(1);
    chk({lo_drv.level[7], lo_drv.drive_en[7]}, 2'h1);
  endtask : t_lower_alt

  task automatic t_alt_in();
    logic [7:0] pats [4] = '{8'h15, 8'h2A, 8'h00, 8'h3F};
    do_reset();
    lo_en = 8'hFF;
    foreach (pats[i]) begin
      lo_val = pats[i];
      tick(2);
      chk(alt_inputs, {pats[i][0], pats[i][2], pats[i][3], pats[i][4],
                       pats[i][5]});
    end
  endtask : t_alt_in

  task automatic t_access();
    board_ext = 1'h1;
    tick(2);
    chk(code_fetch_external, 1'h1);
    board_ext = 1'h0;
    tick(2);
    chk(code_fetch_external, 1'h0);
  endtask : t_access

  initial begin
    rst = 1'h1;
    upper_write = 1'h0;
    lower_write = 1'h0;
    upper_write_data = 8'h00;
    lower_write_data = 8'h00;
    upper_addr_en = 1'h0;
    address_high = 8'h00;
    lower_alt = '0;
    up_en = 8'h00;
    up_val = 8'h00;
    lo_en = 8'h00;
    lo_val = 8'h00;
    board_ext = 1'h0;
    failures = 0;
    total_checks = 0;
    cycles = 0;
    do_reset();
    t_reset();
    t_input();
    t_pull();
    t_addr();
    t_lower_alt();
    t_alt_in();
    t_access();
    wrap_up();
  end
endmodule : quasi_bidir_port_altfunc_tb
